// ---- rsm_pkg.sv ----
package rsm_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SUPPLY_CTRL = 10'h0ff;
  localparam logic [9:0] IDX_RESET_CAUSE = 10'h0ef;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h000;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h001;
  localparam logic [11:0] ADDR_SUPPLY_CTRL = {IDX_SUPPLY_CTRL, 2'b00};
  localparam logic [11:0] ADDR_RESET_CAUSE = {IDX_RESET_CAUSE, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_STAT_BIT = 6;
  localparam int CAUSE_PWRUP_BIT = 1;
  localparam int IRQ_FELL_BIT = 0;
  localparam int IRQ_ROSE_BIT = 1;

  // reset values
  localparam logic MON_EN_RESET = 1'b1;
  localparam logic MON_SEL_RESET = 1'b0;
  localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] WDT_DIV_RESET = 4'hc;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  // power-up release delay in units of 100 us
  localparam int POR_DELAY_100US = 3;
  localparam int POR_DELAY_CYCLES = (POR_DELAY_100US * 100000000) / CLK_PERIOD_PS;

  typedef enum logic [4:0] {
    ST_POR_HOLD = 5'b00001,
    ST_POR_WAIT = 5'b00010,
    ST_RUN = 5'b00100,
    ST_MON_RST = 5'b01000,
    ST_OTHER_RST = 5'b10000
  } rsm_state_t;
endpackage

// ---- rsm_release_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// release of the core reset aligned to pclk, two edges after hold falls
module rsm_release_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  output var logic run
);
  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= !hold;
      stage2_reg <= stage1_reg;
    end
  end

  assign run = stage2_reg;
endmodule
`default_nettype wire

// ---- rsm_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module rsm_top #(
  parameter int POR_DELAY_CYCLES = rsm_pkg::POR_DELAY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_above_thr,
  input wire logic other_reset_req,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic irq,
  output logic cpu_halt,
  output logic sfr_load_defaults,
  output logic irq_timer_disable,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic stack_reinit,
  output logic data_mem_clear,
  output logic [15:0] fetch_addr,
  output logic sysclk_internal_sel,
  output logic wdt_enable,
  output logic [3:0] wdt_clk_div,
  output logic supply_monitor_enable
);
  rsm_pkg::rsm_state_t state_reg;
  rsm_pkg::rsm_state_t state_next;
  logic [15:0] delay_cnt_reg;
  logic [15:0] delay_cnt_next;
  logic mon_en_reg;
  logic mon_sel_reg;
  logic pwrup_flag_reg;
  logic supply_prev_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic [7:0] port_latch_reg;
  logic [15:0] fetch_addr_reg;
  logic wdt_en_reg;
  logic [3:0] wdt_div_reg;
  logic clk_int_reg;
  logic run;

  // bus decode
  wire hit_ctrl = paddr == rsm_pkg::ADDR_SUPPLY_CTRL;
  wire hit_cause = paddr == rsm_pkg::ADDR_RESET_CAUSE;
  wire hit_stat = paddr == rsm_pkg::ADDR_IRQ_STATUS;
  wire hit_mask = paddr == rsm_pkg::ADDR_IRQ_MASK;
  wire hit_any = hit_ctrl | hit_cause | hit_stat | hit_mask;
  wire setup_rd = psel & !penable & !pwrite;
  wire access = psel & penable;
  wire wr_ok = access & pwrite & hit_any;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_cause = wr_ok & hit_cause;
  wire wr_mask = wr_ok & hit_mask;
  wire rd_stat = access & !pwrite & hit_stat;

  assign pready = 1'b1;
  assign pslverr = access & !hit_any;
  assign prdata = prdata_reg;

  // read data; bits 5:0 of control read as zero
  wire [7:0] ctrl_rd = {mon_en_reg, supply_above_thr, 6'h00};
  wire [7:0] cause_rd = {6'h00, pwrup_flag_reg, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                       hit_cause ? {24'h000000, cause_rd} :
                       hit_stat ? {30'h00000000, irq_status_reg} :
                       hit_mask ? {30'h00000000, irq_mask_reg} : 32'h00000000;

  // reset sequencing
  wire hold = state_reg != rsm_pkg::ST_RUN;
  wire mon_trip = mon_en_reg & mon_sel_reg & !supply_above_thr;
  wire exit_power = (state_reg == rsm_pkg::ST_POR_WAIT || state_reg == rsm_pkg::ST_MON_RST) &&
                    state_next == rsm_pkg::ST_RUN;
  wire exit_other = state_reg == rsm_pkg::ST_OTHER_RST && state_next == rsm_pkg::ST_RUN;
  wire supply_fell = supply_prev_reg & !supply_above_thr & mon_en_reg;
  wire supply_rose = !supply_prev_reg & supply_above_thr & mon_en_reg;

  always_comb begin
    state_next = state_reg;
    delay_cnt_next = delay_cnt_reg;
    case (state_reg)
      rsm_pkg::ST_POR_HOLD: begin
        delay_cnt_next = 16'(POR_DELAY_CYCLES - 1);
        if (supply_above_thr) begin
          state_next = rsm_pkg::ST_POR_WAIT;
        end
      end
      rsm_pkg::ST_POR_WAIT: begin
        if (!supply_above_thr) begin
          state_next = rsm_pkg::ST_POR_HOLD;
        end else if (delay_cnt_reg == 16'h0000) begin
          state_next = rsm_pkg::ST_RUN;
        end else begin
          delay_cnt_next = delay_cnt_reg - 16'h0001;
        end
      end
      rsm_pkg::ST_RUN: begin
        if (mon_trip) begin
          state_next = rsm_pkg::ST_MON_RST;
        end else if (other_reset_req) begin
          state_next = rsm_pkg::ST_OTHER_RST;
        end
      end
      rsm_pkg::ST_MON_RST: begin
        if (supply_above_thr) begin
          state_next = rsm_pkg::ST_RUN;
        end
      end
      rsm_pkg::ST_OTHER_RST: begin
        if (mon_trip) begin
          state_next = rsm_pkg::ST_MON_RST;
        end else if (!other_reset_req) begin
          state_next = rsm_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = rsm_pkg::ST_POR_HOLD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= rsm_pkg::ST_POR_HOLD;
      delay_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      delay_cnt_reg <= delay_cnt_next;
    end
  end

  // monitor enable survives every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_en_reg <= rsm_pkg::MON_EN_RESET;
    end else if (wr_ctrl) begin
      mon_en_reg <= pwdata[rsm_pkg::CTRL_EN_BIT];
    end
  end

  // reset source select returns to default in any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_sel_reg <= rsm_pkg::MON_SEL_RESET;
    end else if (hold) begin
      mon_sel_reg <= rsm_pkg::MON_SEL_RESET;
    end else if (wr_cause) begin
      mon_sel_reg <= pwdata[rsm_pkg::CAUSE_PWRUP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrup_flag_reg <= 1'b0;
    end else if (exit_power) begin
      pwrup_flag_reg <= 1'b1;
    end else if (exit_other) begin
      pwrup_flag_reg <= 1'b0;
    end
  end

  // sticky events, read clears, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_prev_reg <= 1'b0;
      irq_status_reg <= 2'h0;
      irq_mask_reg <= rsm_pkg::IRQ_MASK_RESET;
    end else begin
      supply_prev_reg <= supply_above_thr;
      irq_status_reg <= (rd_stat ? 2'h0 : irq_status_reg) | {supply_rose, supply_fell};
      if (wr_mask) begin
        irq_mask_reg <= pwdata[1:0];
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  rsm_release_sync u_release_sync (
    .pclk(pclk),
    .presetn(presetn),
    .hold(hold),
    .run(run)
  );

  // defaults applied while the core is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_reg <= rsm_pkg::PORT_LATCH_RESET;
      fetch_addr_reg <= rsm_pkg::PC_RESET;
      wdt_en_reg <= 1'b1;
      wdt_div_reg <= rsm_pkg::WDT_DIV_RESET;
      clk_int_reg <= 1'b1;
    end else if (!run) begin
      port_latch_reg <= rsm_pkg::PORT_LATCH_RESET;
      fetch_addr_reg <= rsm_pkg::PC_RESET;
      wdt_en_reg <= 1'b1;
      wdt_div_reg <= rsm_pkg::WDT_DIV_RESET;
      clk_int_reg <= 1'b1;
    end
  end

  assign cpu_halt = !run;
  assign sfr_load_defaults = !run;
  assign irq_timer_disable = !run;
  assign stack_reinit = !run;
  assign data_mem_clear = 1'b0;
  assign port_latch = port_latch_reg;
  assign port_open_drain = !run;
  assign weak_pullup_en = 1'b1;
  assign fetch_addr = fetch_addr_reg;
  assign sysclk_internal_sel = clk_int_reg;
  assign wdt_enable = wdt_en_reg;
  assign wdt_clk_div = wdt_div_reg;
  assign supply_monitor_enable = mon_en_reg;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = state_reg == rsm_pkg::ST_POR_HOLD || state_reg == rsm_pkg::ST_POR_WAIT ||
                      state_reg == rsm_pkg::ST_MON_RST;

  property p_pin_drive;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == rsm_pkg::ST_MON_RST || state_reg == rsm_pkg::ST_POR_WAIT) |-> rst_pin_oe && !rst_pin_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("reset pin not driven low");

  property p_mon_trip;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_RUN && mon_en_reg && mon_sel_reg && !supply_above_thr |=>
        state_reg == rsm_pkg::ST_MON_RST && rst_pin_oe;
  endproperty
  a_mon_trip: assert property (p_mon_trip) else $error("supply drop did not reset");

  property p_no_sel;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_RUN && !mon_sel_reg |=> state_reg != rsm_pkg::ST_MON_RST;
  endproperty
  a_no_sel: assert property (p_no_sel) else $error("unselected monitor caused reset");

  property p_mon_release;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_MON_RST && supply_above_thr |=> state_reg == rsm_pkg::ST_RUN ##2 run;
  endproperty
  a_mon_release: assert property (p_mon_release) else $error("monitor release delayed");

  property p_por_delay;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_POR_WAIT && supply_above_thr && delay_cnt_reg != 16'h0000 |=>
        state_reg == rsm_pkg::ST_POR_WAIT && delay_cnt_reg == $past(delay_cnt_reg) - 16'h0001;
  endproperty
  a_por_delay: assert property (p_por_delay) else $error("power-up delay cut short");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_MON_RST && supply_above_thr |=> pwrup_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("power-up flag not set");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_OTHER_RST && !other_reset_req && !mon_trip |=> !pwrup_flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("power-up flag not cleared");

  property p_en_keep;
    @(posedge pclk) disable iff (!presetn)
      state_reg == rsm_pkg::ST_OTHER_RST && !wr_ctrl |=> $stable(mon_en_reg);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("monitor enable changed by reset");

  property p_status_live;
    @(posedge pclk) disable iff (!presetn)
      setup_rd && hit_ctrl |=> prdata[6] == $past(supply_above_thr) && prdata[5:0] == 6'h00;
  endproperty
  a_status_live: assert property (p_status_live) else $error("supply status read wrong");

  property p_release_sync;
    @(posedge pclk) disable iff (!presetn)
      $rose(run) |-> !$past(hold) && !$past(hold, 2);
  endproperty
  a_release_sync: assert property (p_release_sync) else $error("release not synchronised");

  property p_release_defaults;
    @(posedge pclk) disable iff (!presetn)
      $rose(run) |-> wdt_enable && wdt_clk_div == 4'hc && fetch_addr == 16'h0000 && sysclk_internal_sel;
  endproperty
  a_release_defaults: assert property (p_release_defaults) else $error("release defaults wrong");

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      !run |=> port_latch == 8'hff && weak_pullup_en;
  endproperty
  a_latch: assert property (p_latch) else $error("port latches not all ones");
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int POR = 8;
  localparam logic [11:0] A_CTL = rsm_pkg::ADDR_SUPPLY_CTRL;
  localparam logic [11:0] A_CAU = rsm_pkg::ADDR_RESET_CAUSE;
  localparam logic [11:0] A_STA = rsm_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] A_MSK = rsm_pkg::ADDR_IRQ_MASK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic supply = 1'b0, other_req = 1'b0;
  logic [31:0] prdata, rdata, rnd;
  logic pready, pslverr, err, rst_pin_o, rst_pin_oe, irq, cpu_halt, sfr_ld, irq_td, pod, wpu, sreinit, dmc;
  logic sys_int, wdt_en, mon_en;
  logic [7:0] port_latch;
  logic [15:0] fetch_addr;
  logic [3:0] wdt_div;
  int miscompares = 0, comparisons = 0, cycles = 0, seed = 83601, n;
  // model state: monitor enable and sticky event bits
  int m_en = 1, m_stat = 0;

  rsm_top #(.POR_DELAY_CYCLES(POR)) rsm_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_above_thr(supply),
    .other_reset_req(other_req), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .irq(irq),
    .cpu_halt(cpu_halt), .sfr_load_defaults(sfr_ld), .irq_timer_disable(irq_td), .port_latch(port_latch),
    .port_open_drain(pod), .weak_pullup_en(wpu), .stack_reinit(sreinit), .data_mem_clear(dmc),
    .fetch_addr(fetch_addr), .sysclk_internal_sel(sys_int), .wdt_enable(wdt_en), .wdt_clk_div(wdt_div),
    .supply_monitor_enable(mon_en)
  );

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string name, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(name, exp & m, rdata & m);
  endtask

  // supply edges recorded as events while the monitor is powered
  task set_supply(input logic v);
    @(posedge pclk);
    if (m_en != 0 && v !== supply) m_stat = m_stat | (v ? 2 : 1);
    supply <= v;
  endtask

  task wait_halt(input logic v, output int k);
    k = 0;
    while (cpu_halt !== v && k < 500) begin
      @(posedge pclk);
      k++;
    end
  endtask

  initial begin
    repeat (9) @(posedge pclk);
    chk("pin_drive_por", 2'b10, {rst_pin_oe, rst_pin_o});
    chk("halt_group", 5'h1f, {cpu_halt, sfr_ld, irq_td, sreinit, pod});
    chk("port_latch", 8'hff, port_latch);
    chk("pullup_memclr", 2'b10, {wpu, dmc});
    chk("mon_en_por", 1, mon_en);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("held_supply_low", 2'b11, {cpu_halt, rst_pin_oe});
    set_supply(1'b1);
    wait_halt(1'b0, n);
    chk("por_delay", 1, n >= POR);
    chk("pin_released", 0, rst_pin_oe);
    chk("halt_group_run", 5'h00, {cpu_halt, sfr_ld, irq_td, sreinit, pod});
    chk("release_defaults", {16'h0, 2'b11, 4'hc}, {fetch_addr, sys_int, wdt_en, wdt_div});
    chk("latch_after", {8'hff, 1'b1}, {port_latch, wpu});
    rdc("cause_por", A_CAU, 32'h2, 32'h2);
    rdc("ctrl_por", A_CTL, 32'hc0, 32'hffffffff);
    apb(1'b0, A_STA, 32'h0);
    m_stat = 0;
    apb(1'b1, A_MSK, 32'h3);
    set_supply(1'b0);
    repeat (3) @(posedge pclk);
    chk("no_reset_unselected", 0, cpu_halt);
    chk("irq_fell", 1, irq);
    rdc("ctrl_low", A_CTL, 32'h80, 32'hffffffff);
    rdc("stat_fell", A_STA, m_stat, 32'h3);
    m_stat = 0;
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 0, irq);
    set_supply(1'b1);
    repeat (3) @(posedge pclk);
    rnd = $random(seed) & 32'hfffffffc;
    apb(1'b1, A_MSK, rnd);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    rdc("mask_rd", A_MSK, 32'h0, 32'hffffffff);
    rdc("stat_rose", A_STA, m_stat, 32'h3);
    m_stat = 0;
    rnd = $random(seed);
    apb(1'b0, 12'h800 | (rnd[11:0] & 12'h7fc), 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rdata);
    rnd = $random(seed) & 32'h7f;
    apb(1'b1, A_CTL, rnd);
    m_en = 0;
    @(posedge pclk);
    chk("mon_en_off", m_en, mon_en);
    rdc("ctrl_low_bits", A_CTL, 32'h40, 32'hffffffff);
    @(posedge pclk);
    other_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("other_hold", 2'b10, {cpu_halt, rst_pin_oe});
    other_req <= 1'b0;
    wait_halt(1'b0, n);
    chk("other_keeps_en", 0, mon_en);
    rdc("cause_other", A_CAU, 32'h0, 32'h2);
    apb(1'b1, A_CTL, 32'h80);
    m_en = 1;
    apb(1'b1, A_CAU, 32'h2);
    set_supply(1'b0);
    wait_halt(1'b1, n);
    chk("mon_entry", 1, n < 10);
    repeat (2) @(posedge pclk);
    chk("mon_pin", 1, rst_pin_oe);
    set_supply(1'b1);
    wait_halt(1'b0, n);
    chk("mon_no_delay", 1, n < POR);
    chk("mon_en_kept", 2'b10, {mon_en, rst_pin_oe});
    rdc("cause_mon", A_CAU, 32'h2, 32'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
